//--- logic/sdc_pkg.sv
// Purpose: Shared constants and types for the serial DAC input and mode control block
// Assumes: One system clock; serial link pins sampled by that clock
// Notes:   Frame layout is mode field above a 12-bit code
`default_nettype none
package sdc_pkg;
    localparam int          FRAME_BITS     = 16;
    localparam int          CODE_BITS      = 12;
    localparam int          CNT_BITS       = 5;
    localparam int          MODE_HI_POS    = 13;
    localparam int          MODE_LO_POS    = 12;
    localparam int          CODE_LSB_POS   = 0;
    localparam logic [11:0] CODE_RESET     = 12'h000;
    localparam logic [4:0]  CNT_LAST       = 5'h10;
    localparam logic [4:0]  CNT_RESET      = 5'h00;
    localparam logic [15:0] SHIFT_RESET    = 16'h0000;
    localparam logic        PIN_IDLE       = 1'b1;

    typedef enum logic [1:0] {
        SDC_MODE_NORMAL = 2'h0,
        SDC_MODE_PD_1K  = 2'h1,
        SDC_MODE_PD_100K = 2'h2,
        SDC_MODE_PD_TRI = 2'h3
    } sdc_mode_t;

    localparam sdc_mode_t MODE_RESET = SDC_MODE_NORMAL;

    // Controls presented to the analog section
    typedef struct packed {
        logic       amp_enable;
        logic       term_1k;
        logic       term_100k;
        logic       out_connect;
    } sdc_analog_t;

    localparam sdc_analog_t ANALOG_RESET = 4'h9;
endpackage : sdc_pkg
`default_nettype wire

//--- logic/sdc_top.sv
// Purpose: Serial frame capture, DAC code register and power-down mode control
// Assumes: SYS_CLK at 25 MHz oversamples the serial clock (bench 320 ns period)
// Notes:   Serial pins pass two flops; falling edges found on the synced copy
//          Serial clock high and low must each last two system cycles, and
//          frame sync must stay high two system cycles between frames
//          Outputs move two to three system cycles after the sixteenth fall;
//          the analog switch controls follow one cycle after the mode
//          Edges beyond the sixteenth are dropped until frame sync rises
//          The code register reloads from the same frame whenever the mode changes
//          Frame sync is read as a level; nothing is latched on its edges
//
// Function
// - Low frame sync enables the shift register
// - Shift one bit per serial falling edge
// - Sixteenth edge applies code and mode
// - Frame: two ignored, mode, twelve code bits
// - Code loads only on sixteenth edge
// - Early frame sync rise aborts, clears shifter
// - Aborted frame keeps code and mode
// - Reset clears code register to zero
// - Mode decode: normal, 1k, 100k, three-state
// - Power-down disables amplifier, selects termination except in three-state
// - Power-down frame loads its code bits too
// - Data arrives most significant bit first
// - Ignore serial clock while frame sync high
`default_nettype none
module sdc_top
    import sdc_pkg::*;
(
    // System
    input  wire logic                   SYS_CLK,
    input  wire logic                   RESET_N,
    // Serial link
    input  wire logic                   SYNC_N,
    input  wire logic                   SCLK,
    input  wire logic                   DIN,
    // Converter state
    output logic [sdc_pkg::CODE_BITS-1:0] DAC_CODE,
    output sdc_pkg::sdc_mode_t          DAC_MODE,
    output sdc_pkg::sdc_analog_t        ANALOG_CTRL,
    output logic                        UPDATE_PULSE
);
    import sdc_pkg::*;

    // Bit positions of the three pins inside the synchroniser vectors
    localparam int PIN_COUNT = 3;
    localparam int PIN_SYNC  = 2;
    localparam int PIN_SCLK  = 1;
    localparam int PIN_DIN   = 0;

    // Frame progress; one bit changes per step along idle, shift, done
    typedef enum logic [1:0] {
        SDC_FR_IDLE  = 2'b00,
        SDC_FR_SHIFT = 2'b01,
        SDC_FR_DONE  = 2'b11
    } sdc_frame_t;

    // Reset release
    logic                       rst_meta_reg;
    logic                       rst_sync_reg;

    // Serial pins, two stages each, and the clock edge detector
    logic [PIN_COUNT-1:0]       pin_meta_reg;
    logic [PIN_COUNT-1:0]       pin_sync_reg;
    logic                       sclk_prev_reg;

    // Frame assembly
    logic [FRAME_BITS-1:0]      shift_reg;
    logic [FRAME_BITS-1:0]      shift_next;
    logic [CNT_BITS-1:0]        cnt_reg;
    logic [CNT_BITS-1:0]        cnt_next;
    sdc_frame_t                 frame_reg;
    sdc_frame_t                 frame_next;

    // Converter state
    logic [CODE_BITS-1:0]       code_reg;
    logic [CODE_BITS-1:0]       code_next;
    sdc_mode_t                  mode_reg;
    sdc_mode_t                  mode_next;
    logic                       update_reg;
    logic                       update_next;
    sdc_analog_t                analog_reg;
    sdc_analog_t                analog_next;

    // Synchronised pin levels
    wire logic [PIN_COUNT-1:0]  pin_raw  = {SYNC_N, SCLK, DIN};
    wire logic                  sync_n_s = pin_sync_reg[PIN_SYNC];
    wire logic                  sclk_s   = pin_sync_reg[PIN_SCLK];
    wire logic                  din_s    = pin_sync_reg[PIN_DIN];

    // Latency from a pin fall to the outputs is two synchroniser flops,
    // the edge detector and the load. At a 25 MHz system clock this caps
    // the serial clock near 6 MHz, far below what a host may drive; a
    // faster link needs a faster system clock. A sync pulse shorter than
    // two system cycles may be missed, which drops the frame after it
    // because the block still believes the old frame is done.

    // Reset release through two flops; assertion stays asynchronous so the
    // outputs clear even while the system clock is stopped
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_meta_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
        end
    end

    // Second stage is the only reset copy the rest of the block reads
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_sync_reg <= 1'b0;
        end else begin
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // Pins come from the host's domain; first stage read only by second
    for (genvar p = 0; p < PIN_COUNT; p++) begin : g_pin_sync
        always_ff @(posedge SYS_CLK or negedge rst_sync_reg) begin
            if (!rst_sync_reg) begin
                pin_meta_reg[p] <= PIN_IDLE;
                pin_sync_reg[p] <= PIN_IDLE;
            end else begin
                pin_meta_reg[p] <= pin_raw[p];
                pin_sync_reg[p] <= pin_meta_reg[p];
            end
        end
    end

    // Starts at the idle level, so leaving reset never looks like a fall
    always_ff @(posedge SYS_CLK or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            sclk_prev_reg <= PIN_IDLE;
        end else begin
            sclk_prev_reg <= sclk_s;
        end
    end

    // edges count only inside a frame
    wire logic frame_on  = !sync_n_s;
    wire logic sclk_fall = sclk_prev_reg && !sclk_s;
    // edges past the sixteenth are ignored
    wire logic room      = (cnt_reg < CNT_LAST) && (frame_reg != SDC_FR_DONE);
    wire logic take_bit  = frame_on && sclk_fall && room;
    wire logic last_bit  = take_bit && (cnt_reg == CNT_LAST - 5'h01);

    // frame progress; done holds off further edges until sync rises
    always_comb begin
        frame_next = frame_reg;
        unique case (frame_reg)
            SDC_FR_IDLE: begin
                if (frame_on) begin
                    frame_next = SDC_FR_SHIFT;
                end
            end
            // rise before the sixteenth abandons the frame
            SDC_FR_SHIFT: begin
                if (!frame_on) begin
                    frame_next = SDC_FR_IDLE;
                end else if (last_bit) begin
                    frame_next = SDC_FR_DONE;
                end
            end
            // sync may idle low here until the next frame
            SDC_FR_DONE: begin
                if (!frame_on) begin
                    frame_next = SDC_FR_IDLE;
                end
            end
            // Code 2'b10 is unused; recover to idle
            default: begin
                frame_next = SDC_FR_IDLE;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            frame_reg <= SDC_FR_IDLE;
        end else begin
            frame_reg <= frame_next;
        end
    end

    // field positions in the completed word
    wire logic [FRAME_BITS-1:0] word        = {shift_reg[FRAME_BITS-2:0], din_s};
    wire logic [CODE_BITS-1:0]  new_code    = word[CODE_LSB_POS +: CODE_BITS];
    // the two mode bits sit just above the code
    wire logic                  mode_bit_hi = word[MODE_HI_POS];
    wire logic                  mode_bit_lo = word[MODE_LO_POS];
    wire sdc_mode_t             new_mode    = sdc_mode_t'({mode_bit_hi, mode_bit_lo});

    // shifter held clear while frame sync is high
    // one bit per edge, first bit ends up at the top
    for (genvar b = 0; b < FRAME_BITS; b++) begin : g_shift
        assign shift_next[b] = !frame_on ? SHIFT_RESET[b]
                             : take_bit  ? word[b]
                             : shift_reg[b];
    end

    // five-bit count cleared whenever frame sync is high
    assign cnt_next = !frame_on ? CNT_RESET
                    : take_bit  ? cnt_reg + 5'h01
                    : cnt_reg;

    // only a completed frame touches code and mode
    assign code_next   = last_bit ? new_code : code_reg;
    assign mode_next   = last_bit ? new_mode : mode_reg;
    assign update_next = last_bit;

    // mode drives amplifier and termination switches
    always_comb begin
        analog_next = ANALOG_RESET;
        unique case (mode_reg)
            SDC_MODE_NORMAL: begin
                analog_next = ANALOG_RESET;
            end
            SDC_MODE_PD_1K: begin
                analog_next = '{amp_enable: 1'b0, term_1k: 1'b1,
                                term_100k: 1'b0, out_connect: 1'b0};
            end
            SDC_MODE_PD_100K: begin
                analog_next = '{amp_enable: 1'b0, term_1k: 1'b0,
                                term_100k: 1'b1, out_connect: 1'b0};
            end
            SDC_MODE_PD_TRI: begin
                analog_next = '{amp_enable: 1'b0, term_1k: 1'b0,
                                term_100k: 1'b0, out_connect: 1'b0};
            end
        endcase
    end

    // Shifter and counter share the frame's clearing path
    always_ff @(posedge SYS_CLK or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            shift_reg <= SHIFT_RESET;
        end else begin
            shift_reg <= shift_next;
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            cnt_reg <= CNT_RESET;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    // code clears at reset and stays until a full frame
    // a frame that changes mode loads its code bits too
    always_ff @(posedge SYS_CLK or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            code_reg <= CODE_RESET;
        end else begin
            code_reg <= code_next;
        end
    end

    // Mode is held apart from the code, loaded by the same strobe
    always_ff @(posedge SYS_CLK or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            mode_reg <= MODE_RESET;
        end else begin
            mode_reg <= mode_next;
        end
    end

    // One-cycle strobe, registered with the code it announces
    always_ff @(posedge SYS_CLK or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            update_reg <= 1'b0;
        end else begin
            update_reg <= update_next;
        end
    end

    // Analog controls lag mode by one cycle so the output stays registered
    always_ff @(posedge SYS_CLK or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            analog_reg <= ANALOG_RESET;
        end else begin
            analog_reg <= analog_next;
        end
    end

    assign DAC_CODE     = code_reg;
    assign DAC_MODE     = mode_reg;
    assign ANALOG_CTRL  = analog_reg;
    assign UPDATE_PULSE = update_reg;

endmodule : sdc_top
`default_nettype wire

//--- verif/sdc_checker.sv
// Purpose: Port properties of the DAC front end
// Assumes: Host holds sync low a while after the last fall
// Notes:   8-cycle pulse gap is far below a legal frame
`default_nettype none
module sdc_checker
    import sdc_pkg::*;
(
    input wire logic                 SYS_CLK,
    input wire logic                 RESET_N,
    input wire logic                 SYNC_N,
    input wire logic                 SCLK,
    input wire logic [11:0]          DAC_CODE,
    input wire sdc_pkg::sdc_mode_t   DAC_MODE,
    input wire sdc_pkg::sdc_analog_t ANALOG_CTRL,
    input wire logic                 UPDATE_PULSE
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);
    function automatic logic [3:0] amap(input logic [1:0] m);
        return (m == 2'h0) ? 4'h9 : (m == 2'h1) ? 4'h4 : (m == 2'h2) ? 4'h2 : 4'h0;
    endfunction : amap
    a_code_on_load: assert property ($changed(DAC_CODE) |-> UPDATE_PULSE)
        else $error("code moved alone");
    a_mode_on_load: assert property ($changed(DAC_MODE) |-> UPDATE_PULSE)
        else $error("mode moved alone");
    a_pulse_gap: assert property (UPDATE_PULSE |=> !UPDATE_PULSE [*8])
        else $error("pulse too long");
    a_load_in_frame: assert property (UPDATE_PULSE |-> !$past(SYNC_N, 3))
        else $error("load outside frame");
    a_load_on_fall: assert property (UPDATE_PULSE |-> !$past(SCLK, 2))
        else $error("load without fall");
    a_analog_map: assert property (ANALOG_CTRL == amap($past(DAC_MODE)))
        else $error("bad analog control");
    a_pd_amp_off: assert property (DAC_MODE != SDC_MODE_NORMAL |=> !ANALOG_CTRL.amp_enable)
        else $error("amp on in power-down");
    a_reset_zero: assert property ($rose(RESET_N) |-> DAC_CODE == CODE_RESET)
        else $error("code not cleared");
    c_load: cover property (UPDATE_PULSE);
    c_tri: cover property (DAC_MODE == SDC_MODE_PD_TRI);
    c_abort: cover property ($rose(SYNC_N) && !UPDATE_PULSE);
endmodule : sdc_checker
`default_nettype wire

//--- verif/sdc_host_model.sv
// Purpose: Serial host driving sync, clock and data
// Assumes: Link period of 8 system cycles
// Notes:   Data line shows inverse of last bit once released
`default_nettype none
module sdc_host_model (
    input wire logic SYS_CLK,
    output var logic SYNC_N,
    output var logic SCLK,
    output var logic DIN
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        SYNC_N = 1'b1;
        SCLK = 1'b1;
        DIN = 1'b0;
    end
    task automatic send(input logic [15:0] w, input int n, input bit cont, input bit hold);
        if (!cont) begin
            SYNC_N = 1'b1;
            repeat (3) @(negedge SYS_CLK);
            SYNC_N = 1'b0;
        end
        for (int i = 15; i > 15 - n; i--) begin
            DIN = w[i];
            repeat (4) @(negedge SYS_CLK);
            SCLK = 1'b0;
            repeat (4) @(negedge SYS_CLK);
            SCLK = 1'b1;
        end
        repeat (4) @(negedge SYS_CLK);
        SYNC_N = hold ? 1'b0 : 1'b1;
        DIN = ~DIN;
    endtask : send
endmodule : sdc_host_model
`default_nettype wire

//--- verif/sdc_top_bench.sv
// Purpose: Self-checking bench of the DAC front end
// Assumes: Host model owns the serial pins
// Notes:   Pulse count shows aborted and extra edges
`default_nettype none
module sdc_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import sdc_pkg::*;
    logic SYS_CLK = 1'b0, RESET_N = 1'b0, SYNC_N, SCLK, DIN, UPDATE_PULSE;
    logic [11:0] DAC_CODE;
    sdc_mode_t DAC_MODE;
    sdc_analog_t ANALOG_CTRL;
    int num_errors = 0, n_tests = 0, pulses = 0;
    logic [19:0] rows [5] = '{20'h0a5c9, 20'hd1234, 20'h6fff2, 20'hb0000, 20'h08019};
    always #20 SYS_CLK = ~SYS_CLK;
    always @(negedge SYS_CLK) if (UPDATE_PULSE === 1'b1) pulses <= pulses + 1;
    sdc_host_model sdc_host_model_i (.SYS_CLK(SYS_CLK), .SYNC_N(SYNC_N), .SCLK(SCLK), .DIN(DIN));
    sdc_top sdc_top_i (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .SYNC_N(SYNC_N), .SCLK(SCLK),
        .DIN(DIN), .DAC_CODE(DAC_CODE), .DAC_MODE(DAC_MODE), .ANALOG_CTRL(ANALOG_CTRL),
        .UPDATE_PULSE(UPDATE_PULSE));
    task automatic chk(input logic [15:0] w, input logic [3:0] a, input int p);
        repeat (2) @(negedge SYS_CLK);
        n_tests++;
        if (DAC_CODE !== w[11:0] || DAC_MODE !== w[13:12] || ANALOG_CTRL !== a || pulses != p) begin
            num_errors++;
            $display("mismatch %0t frame %h", $time, w);
        end
    endtask : chk
    task automatic give_verdict;
        if (num_errors == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (16) @(negedge SYS_CLK);
        RESET_N = 1'b1;
        repeat (8) @(negedge SYS_CLK);
        chk(16'h0000, 4'h9, 0);
        for (int i = 0; i < 5; i++) begin
            sdc_host_model_i.send(rows[i][19:4], 16, 0, 0);
            chk(rows[i][19:4], rows[i][3:0], i + 1);
        end
        sdc_host_model_i.send(16'h3fff, 15, 0, 0);
        chk(16'h0801, 4'h9, 5);
        sdc_host_model_i.send(16'h1abc, 8, 0, 1);
        sdc_host_model_i.send(16'hbc00, 8, 1, 0);
        chk(16'h1abc, 4'h4, 6);
        sdc_host_model_i.send(16'h0123, 16, 0, 1);
        sdc_host_model_i.send(16'hffff, 8, 1, 0);
        chk(16'h0123, 4'h9, 7);
        sdc_host_model_i.send(16'h2456, 16, 0, 0);
        chk(16'h2456, 4'h2, 8);
        RESET_N = 1'b0;
        repeat (4) @(negedge SYS_CLK);
        RESET_N = 1'b1;
        repeat (8) @(negedge SYS_CLK);
        chk(16'h0000, 4'h9, 8);
        sdc_host_model_i.send(16'h1fff, 16, 0, 0);
        chk(16'h1fff, 4'h4, 9);
        give_verdict();
    end
endmodule : sdc_top_bench
bind sdc_top sdc_checker sdc_checker_i (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .SYNC_N(SYNC_N),
    .SCLK(SCLK), .DAC_CODE(DAC_CODE), .DAC_MODE(DAC_MODE), .ANALOG_CTRL(ANALOG_CTRL),
    .UPDATE_PULSE(UPDATE_PULSE));
`default_nettype wire
